// *** hw/irdcfg_top.sv ***
// Purpose: Configuration register bank of an infrared controller with IRQ/DMA routing and power control.
// Assumes: Single clock; the sleep request pin and infrared traffic detect pass a two-flop synchroniser.
// Notes:   Requests get waitrequest high in the first cycle and are answered in the second.
//
// Register access over Avalon-MM was chosen for this implementation.
`default_nettype none

module irdcfg_top
  import irdcfg_pkg::*;
(
  input  wire  logic        clk_sys,
  input  wire  logic        nrst,
  input  wire  logic [9:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [3:0]  avs_byteenable,
  input  wire  logic [31:0] avs_writedata,
  output logic       [31:0] avs_readdata,
  output logic              avs_waitrequest,
  input  wire  logic        shared_memory_mode,
  input  wire  logic        sleep_request_pin_n,
  input  wire  logic        ir_traffic_detect,
  input  wire  logic        uart_irq_in,
  input  wire  logic        ir_irq_in,
  input  wire  logic        uart_access,
  input  wire  logic [2:0]  general_output_in,
  input  wire  logic [2:0]  test_signal_in,
  output logic       [15:0] isa_irq,
  output logic       [3:0]  dma1_channel_onehot,
  output logic       [3:0]  dma2_channel_onehot,
  output logic              ir_ctrl_reset,
  output logic              subsys_access_block,
  output logic              uart_clock_enable,
  output logic              ir_clock_enable,
  output logic              all_powered_down,
  output logic       [2:0]  general_output
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] sync_meta;
  logic [2:0] sync_stable;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync_meta   <= 3'h7;
      sync_stable <= 3'h7;
    end else begin
      sync_meta   <= {sleep_request_pin_n, ~ir_traffic_detect, 1'b1};
      sync_stable <= sync_meta;
    end
  end

  logic pin_sleep_req;
  logic ir_traffic;
  assign pin_sleep_req = ~sync_stable[2];
  assign ir_traffic    = ~sync_stable[1];

  // ---------------------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------------------
  irdcfg_req_type       req;
  irdcfg_bus_state_type bus_state;
  logic [7:0]           idx;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 lane0;

  assign req     = '{read: avs_read, write: avs_write, address: avs_address,
                     byteenable: avs_byteenable, writedata: avs_writedata};
  assign idx     = req.address[9:2];
  assign lane0   = req.byteenable[0];
  assign wr_fire = (bus_state == IRDCFG_BUS_ACK) && req.write;
  assign rd_fire = (bus_state == IRDCFG_BUS_ACK) && req.read;
  assign avs_waitrequest = (req.read || req.write) && (bus_state != IRDCFG_BUS_ACK);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_state <= IRDCFG_BUS_IDLE;
    end else begin
      case (bus_state)
        IRDCFG_BUS_IDLE: begin
          if (req.read || req.write) begin
            bus_state <= IRDCFG_BUS_ACK;
          end
        end
        IRDCFG_BUS_ACK: begin
          bus_state <= IRDCFG_BUS_IDLE;
        end
        default: begin
          bus_state <= IRDCFG_BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0]         pwr;
  logic [7:0]         base_low;
  irdcfg_irq_cfg_type irq_cfg;
  logic [2:0]         dma1;
  logic [2:0]         dma2;
  logic [1:0]         subsys_en;
  logic               cfg_wr;
  logic [7:0]         wbyte;

  assign wbyte  = req.writedata[7:0];
  assign cfg_wr = wr_fire && lane0 && !pwr[IRDCFG_BIT_LOCK];

  // Lock is sticky; only nrst clears it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr <= IRDCFG_PWR_RESET;
    end else if (cfg_wr && idx == IRDCFG_IDX_POWER_CONTROL) begin
      pwr <= (wbyte & IRDCFG_PWR_MASK) | (pwr & (8'h1 << IRDCFG_BIT_LOCK));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      base_low <= 8'h00;
    end else if (cfg_wr && idx == IRDCFG_IDX_IR_BASE_LOW) begin
      base_low <= wbyte & IRDCFG_BASE_MASK;
    end
  end

  // Software reset does not touch these registers.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_cfg <= '0;
    end else if (cfg_wr) begin
      if (idx == IRDCFG_IDX_UART_IRQ_SEL) begin
        irq_cfg.uart_sel <= wbyte[3:0];
      end
      if (idx == IRDCFG_IDX_UART_IRQ_TYPE) begin
        irq_cfg.uart_type <= wbyte[1:0];
      end
      if (idx == IRDCFG_IDX_IR_IRQ_SEL) begin
        irq_cfg.ir_sel <= wbyte[3:0];
      end
      if (idx == IRDCFG_IDX_IR_IRQ_TYPE) begin
        irq_cfg.ir_type <= wbyte[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dma1 <= IRDCFG_DMA_NONE;
      dma2 <= IRDCFG_DMA_NONE;
    end else if (cfg_wr && !shared_memory_mode) begin
      if (idx == IRDCFG_IDX_DMA1_ROUTE) begin
        dma1 <= wbyte[2:0];
      end
      if (idx == IRDCFG_IDX_DMA2_ROUTE) begin
        dma2 <= wbyte[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      subsys_en <= 2'h0;
    end else if (cfg_wr && idx == IRDCFG_IDX_SUBSYS_CTRL) begin
      subsys_en <= wbyte[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [2:0]  dma1_view;
  logic [2:0]  dma2_view;
  logic [31:0] next_readdata;

  assign dma1_view = shared_memory_mode ? IRDCFG_DMA_NONE : dma1;
  assign dma2_view = shared_memory_mode ? IRDCFG_DMA_NONE : dma2;

  always_comb begin
    next_readdata = IRDCFG_UNMAPPED_DATA;
    case (idx)
      IRDCFG_IDX_POWER_CONTROL: next_readdata = {24'h0, pwr};
      IRDCFG_IDX_IR_BASE_LOW:   next_readdata = {24'h0, base_low};
      IRDCFG_IDX_UART_IRQ_SEL:  next_readdata = {28'h0, irq_cfg.uart_sel};
      IRDCFG_IDX_UART_IRQ_TYPE: next_readdata = {30'h0, irq_cfg.uart_type};
      IRDCFG_IDX_IR_IRQ_SEL:    next_readdata = {28'h0, irq_cfg.ir_sel};
      IRDCFG_IDX_IR_IRQ_TYPE:   next_readdata = {30'h0, irq_cfg.ir_type};
      IRDCFG_IDX_DMA1_ROUTE:    next_readdata = {29'h0, dma1_view};
      IRDCFG_IDX_DMA2_ROUTE:    next_readdata = {29'h0, dma2_view};
      IRDCFG_IDX_SUBSYS_CTRL:   next_readdata = {30'h0, subsys_en};
      default:                  next_readdata = IRDCFG_UNMAPPED_DATA;
    endcase
  end

  // Read data is registered when the request is first seen, so it is stable at the ack edge.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state == IRDCFG_BUS_IDLE && req.read) begin
      avs_readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset, power and test-mode control
  // ---------------------------------------------------------------------------
  logic power_down;
  logic pd_enable;

  assign pd_enable  = pwr[IRDCFG_BIT_PD_EN];
  assign power_down = pd_enable && (pwr[IRDCFG_BIT_PD] || pin_sleep_req);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ir_ctrl_reset       <= 1'b0;
      subsys_access_block <= 1'b0;
      all_powered_down    <= 1'b0;
      uart_clock_enable   <= 1'b1;
      ir_clock_enable     <= 1'b1;
    end else begin
      ir_ctrl_reset       <= pwr[IRDCFG_BIT_SW_RESET];
      subsys_access_block <= pwr[IRDCFG_BIT_SW_RESET];
      all_powered_down    <= power_down;
      // UART gated when powered down, when disabled under conservation, or idle under auto saving.
      uart_clock_enable <= !power_down && !(pd_enable && !subsys_en[0])
                           && !(pwr[IRDCFG_BIT_APM] && !uart_access);
      ir_clock_enable   <= !power_down && !(pd_enable && !subsys_en[1]);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      general_output <= 3'h0;
    end else begin
      general_output <= pwr[IRDCFG_BIT_TEST] ? test_signal_in : general_output_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt routing
  // ---------------------------------------------------------------------------
  logic uart_prev;
  logic ir_prev;
  logic ir_src;
  logic uart_drive;
  logic ir_drive;

  // Wakeup merges onto the infrared request line while powered down.
  assign ir_src = ir_irq_in || (pwr[IRDCFG_BIT_WAKE] && power_down && ir_traffic);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      uart_prev <= 1'b0;
      ir_prev   <= 1'b0;
    end else begin
      uart_prev <= uart_irq_in;
      ir_prev   <= ir_src;
    end
  end

  // Level type drives the line low while active; edge type drives a one-cycle high pulse.
  assign uart_drive = (irq_cfg.uart_type == IRDCFG_TYPE_EDGE) ? (uart_irq_in && !uart_prev) : 1'b0;
  assign ir_drive   = (irq_cfg.ir_type == IRDCFG_TYPE_EDGE) ? (ir_src && !ir_prev) : 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      logic uart_hit;
      logic ir_hit;
      logic uart_lvl;
      logic ir_lvl;
      assign uart_hit = (irq_cfg.uart_sel == 4'(gi)) && (irq_cfg.uart_sel != IRDCFG_IRQ_NONE);
      assign ir_hit   = (irq_cfg.ir_sel == 4'(gi)) && (irq_cfg.ir_sel != IRDCFG_IRQ_NONE);
      assign uart_lvl = uart_hit && (irq_cfg.uart_type == IRDCFG_TYPE_LEVEL);
      assign ir_lvl   = ir_hit && (irq_cfg.ir_type == IRDCFG_TYPE_LEVEL);
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          isa_irq[gi] <= 1'b0;
        end else if ((uart_lvl && uart_irq_in) || (ir_lvl && ir_src)) begin
          isa_irq[gi] <= 1'b0;
        end else if (uart_lvl || ir_lvl) begin
          isa_irq[gi] <= 1'b1;
        end else begin
          isa_irq[gi] <= (uart_hit && uart_drive) || (ir_hit && ir_drive);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // DMA routing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dma1_channel_onehot <= 4'h0;
      dma2_channel_onehot <= 4'h0;
    end else begin
      dma1_channel_onehot <= (dma1_view < 3'h4) ? 4'(4'h1 << dma1_view[1:0]) : 4'h0;
      dma2_channel_onehot <= (dma2_view < 3'h4) ? 4'(4'h1 << dma2_view[1:0]) : 4'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_pwr_write_set_lock;
    cfg_wr && idx == IRDCFG_IDX_POWER_CONTROL && wbyte[IRDCFG_BIT_LOCK];
  endsequence

  a_lock_blocks_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    pwr[IRDCFG_BIT_LOCK] && wr_fire && idx == IRDCFG_IDX_UART_IRQ_SEL |=> $stable(irq_cfg.uart_sel))
    else $error("Locked write changed UART select.");

  a_lock_sticky_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_pwr_write_set_lock |=> pwr[IRDCFG_BIT_LOCK] [*8])
    else $error("Lock bit cleared without hardware reset.");

  a_base_low_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    base_low[2:0] == 3'h0)
    else $error("Base low bits 2:0 not zero.");

  a_pd_needs_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
    !pwr[IRDCFG_BIT_PD_EN] |=> !all_powered_down)
    else $error("Power down accepted while disabled.");

  a_soft_reset_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    pwr[IRDCFG_BIT_SW_RESET] |=> ir_ctrl_reset && subsys_access_block)
    else $error("Software reset not driven.");

  a_dma_shared_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
    shared_memory_mode && rd_fire && idx == IRDCFG_IDX_DMA1_ROUTE |-> avs_readdata == 32'h0000_0004)
    else $error("Shared memory DMA route not 04h.");

  a_dma2_route_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    !shared_memory_mode && dma2 == 3'h2 ##1 !shared_memory_mode |-> dma2_channel_onehot == 4'h4)
    else $error("Second DMA route wrong.");

  a_test_mux_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    pwr[IRDCFG_BIT_TEST] |=> general_output == $past(test_signal_in))
    else $error("Test mode output not muxed.");

  a_uart_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_cfg.uart_sel == 4'h3 && irq_cfg.uart_type == IRDCFG_TYPE_LEVEL && uart_irq_in |=> !isa_irq[3])
    else $error("UART level interrupt not low.");

  a_ir_irq_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_cfg.ir_sel == 4'hC && irq_cfg.ir_type == IRDCFG_TYPE_EDGE && ir_src && !ir_prev |=> isa_irq[12])
    else $error("Infrared edge interrupt missing.");

endmodule : irdcfg_top

`default_nettype wire

// *** hw/irdcfg_pkg.sv ***
// Purpose: Shared constants and types for the infrared configuration register bank.
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word.
// Notes:   Printed offsets are register indices; byte address is four times the index.
`default_nettype none

package irdcfg_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IRDCFG_IDX_POWER_CONTROL = 8'h02;
  localparam logic [7:0] IRDCFG_IDX_IR_BASE_LOW   = 8'h63;
  localparam logic [7:0] IRDCFG_IDX_UART_IRQ_SEL  = 8'h70;
  localparam logic [7:0] IRDCFG_IDX_UART_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IRDCFG_IDX_IR_IRQ_SEL    = 8'h72;
  localparam logic [7:0] IRDCFG_IDX_IR_IRQ_TYPE   = 8'h73;
  localparam logic [7:0] IRDCFG_IDX_DMA1_ROUTE    = 8'h74;
  localparam logic [7:0] IRDCFG_IDX_DMA2_ROUTE    = 8'h75;
  localparam logic [7:0] IRDCFG_IDX_SUBSYS_CTRL   = 8'h80;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int          IRDCFG_BIT_SW_RESET   = 7;
  localparam int          IRDCFG_BIT_LOCK       = 6;
  localparam int          IRDCFG_BIT_TEST       = 5;
  localparam int          IRDCFG_BIT_APM        = 4;
  localparam int          IRDCFG_BIT_WAKE       = 2;
  localparam int          IRDCFG_BIT_PD_EN      = 1;
  localparam int          IRDCFG_BIT_PD         = 0;
  localparam logic [7:0]  IRDCFG_PWR_MASK       = 8'hF7;
  localparam logic [7:0]  IRDCFG_PWR_RESET      = 8'h02;
  localparam logic [7:0]  IRDCFG_BASE_MASK      = 8'hF8;
  localparam logic [3:0]  IRDCFG_IRQ_NONE       = 4'h0;
  localparam logic [1:0]  IRDCFG_TYPE_LEVEL     = 2'h1;
  localparam logic [1:0]  IRDCFG_TYPE_EDGE      = 2'h2;
  localparam logic [2:0]  IRDCFG_DMA_NONE       = 3'h4;
  localparam logic [31:0] IRDCFG_UNMAPPED_DATA  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       read;
    logic       write;
    logic [9:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } irdcfg_req_type;

  typedef struct packed {
    logic [3:0] uart_sel;
    logic [1:0] uart_type;
    logic [3:0] ir_sel;
    logic [1:0] ir_type;
  } irdcfg_irq_cfg_type;

  typedef enum logic [1:0] {
    IRDCFG_BUS_IDLE = 2'b00,
    IRDCFG_BUS_ACK  = 2'b01
  } irdcfg_bus_state_type;

endpackage : irdcfg_pkg

`default_nettype wire

// *** test/irdcfg_peer_model.sv ***
// Purpose: Stands in for the subsystems and pins around the configuration bank.
// Assumes: One clock; the bench sets the command bits just after a rising edge.
// Notes:   The cmd-driven outputs are registered, so each command shows one edge later; the two pattern outputs are constant.
`default_nettype none

module irdcfg_peer_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [4:0] cmd,
  output logic            uart_irq_in,
  output logic            ir_irq_in,
  output logic            uart_access,
  output logic            ir_traffic_detect,
  output logic            sleep_request_pin_n,
  output logic      [2:0] general_output_in,
  output logic      [2:0] test_signal_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // The two output patterns differ in every bit, so a wrong source shows at once.
  assign general_output_in = 3'h2;
  assign test_signal_in    = 3'h5;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      uart_irq_in         <= 1'b0;
      ir_irq_in           <= 1'b0;
      uart_access         <= 1'b0;
      ir_traffic_detect   <= 1'b0;
      sleep_request_pin_n <= 1'b1;
    end else begin
      uart_irq_in         <= cmd[0];
      ir_irq_in           <= cmd[1];
      uart_access         <= cmd[2];
      ir_traffic_detect   <= cmd[3];
      sleep_request_pin_n <= ~cmd[4];
    end
  end
endmodule : irdcfg_peer_model

`default_nettype wire

// *** test/irdcfg_top_tb.sv ***
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Avalon-MM master tasks; registers sit at byte address four times the index.
// Notes:   Waits after writes cover output registers and pin synchronisers.
`default_nettype none

module irdcfg_top_tb
  import irdcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest, shared_memory_mode;
  logic [9:0]  avs_address;
  logic [3:0]  avs_byteenable, dma1_channel_onehot, dma2_channel_onehot;
  logic [31:0] avs_writedata, avs_readdata;
  logic [4:0]  cmd;
  logic        uart_irq_in, ir_irq_in, uart_access, ir_traffic_detect, sleep_request_pin_n;
  logic [2:0]  general_output_in, test_signal_in, general_output;
  logic [15:0] isa_irq;
  logic        ir_ctrl_reset, subsys_access_block, uart_clock_enable, ir_clock_enable, all_powered_down;
  int          errors = 0;
  int          samples_checked = 0;
  int          pulse_cnt = 0;
  int          pulse_line = 0;
  logic [7:0]  ridx [9] = '{8'h02, 8'h63, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h10};
  logic [7:0]  rrst [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00};
  logic [3:0]  codes [7] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hF};

  irdcfg_top irdcfg_top_inst (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .shared_memory_mode(shared_memory_mode), .sleep_request_pin_n(sleep_request_pin_n),
    .ir_traffic_detect(ir_traffic_detect), .uart_irq_in(uart_irq_in), .ir_irq_in(ir_irq_in),
    .uart_access(uart_access), .general_output_in(general_output_in), .test_signal_in(test_signal_in),
    .isa_irq(isa_irq), .dma1_channel_onehot(dma1_channel_onehot), .dma2_channel_onehot(dma2_channel_onehot),
    .ir_ctrl_reset(ir_ctrl_reset), .subsys_access_block(subsys_access_block),
    .uart_clock_enable(uart_clock_enable), .ir_clock_enable(ir_clock_enable),
    .all_powered_down(all_powered_down), .general_output(general_output));

  irdcfg_peer_model irdcfg_peer_model_inst (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd),
    .uart_irq_in(uart_irq_in), .ir_irq_in(ir_irq_in), .uart_access(uart_access),
    .ir_traffic_detect(ir_traffic_detect), .sleep_request_pin_n(sleep_request_pin_n),
    .general_output_in(general_output_in), .test_signal_in(test_signal_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Counts cycles in which the watched line carries a pulse.
  always @(posedge clk_sys) begin
    if (isa_irq[pulse_line] === 1'b1) pulse_cnt <= pulse_cnt + 1;
  end

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Values read right after an edge are those sampled at that edge.
  task automatic xfer(input logic wr_n, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_read      <= ~wr_n;
    avs_write     <= wr_n;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    xfer(1'b0, idx, 8'h00, x);
    chk(nm, {24'h0, e}, x);
  endtask : rdc

  task automatic settle;
    repeat (5) @(posedge clk_sys);
  endtask : settle

  task automatic pulse_chk(input int line, input int bitn, input int e);
    int base;
    pulse_line = line;
    settle();
    base = pulse_cnt;
    cmd[bitn] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    cmd[bitn] <= 1'b0;
    settle();
    chk("pulse count", e, pulse_cnt - base);
  endtask : pulse_chk

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h000;
    avs_byteenable = 4'hF; avs_writedata = 32'h0; shared_memory_mode = 1'b0; cmd = 5'h00;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) rdc("reset value", ridx[i], rrst[i]);
    $display("test reset done");
    wr(8'h63, 8'hFF);
    rdc("base low", 8'h63, 8'hF8);
    wr(8'h70, 8'hFF);
    rdc("uart sel reserved", 8'h70, 8'h0F);
    wr(8'h71, 8'h01);
    for (int i = 0; i < 7; i++) begin
      wr(8'h70, {4'h0, codes[i]});
      settle();
      chk("uart level idle", 32'h1 << codes[i], {16'h0, isa_irq});
      cmd[0] <= 1'b1;
      settle();
      chk("uart level active", 32'h0, {16'h0, isa_irq});
      cmd[0] <= 1'b0;
    end
    wr(8'h70, 8'h00);
    settle();
    chk("uart unassigned", 32'h0, {16'h0, isa_irq});
    wr(8'h71, 8'h02);
    wr(8'h70, 8'h03);
    pulse_chk(3, 0, 1);
    wr(8'h70, 8'h00);
    wr(8'h73, 8'h01);
    wr(8'h72, 8'h05);
    settle();
    chk("ir level idle", 32'h20, {16'h0, isa_irq});
    wr(8'h73, 8'h02);
    wr(8'h72, 8'h0C);
    pulse_chk(12, 1, 1);
    $display("test irq done");
    for (int c = 0; c < 5; c++) begin
      wr(8'h74, 8'(c));
      wr(8'h75, 8'(4 - c));
      settle();
      chk("dma1", (c < 4) ? (32'h1 << c) : 32'h0, {28'h0, dma1_channel_onehot});
      chk("dma2", (c > 0) ? (32'h1 << (4 - c)) : 32'h0, {28'h0, dma2_channel_onehot});
      rdc("dma1 read", 8'h74, 8'(c));
    end
    shared_memory_mode <= 1'b1;
    wr(8'h75, 8'h01);
    rdc("dma1 shared", 8'h74, 8'h04);
    rdc("dma2 shared", 8'h75, 8'h04);
    chk("dma2 shared route", 32'h0, {28'h0, dma2_channel_onehot});
    shared_memory_mode <= 1'b0;
    $display("test dma done");
    wr(8'h02, 8'h03);
    settle();
    chk("pd by bit", 32'h1, {31'h0, all_powered_down});
    wr(8'h02, 8'h00);
    wr(8'h02, 8'h01);
    cmd[4] <= 1'b1;
    settle();
    chk("pd disabled", 32'h0, {31'h0, all_powered_down});
    wr(8'h02, 8'h02);
    settle();
    chk("pd by pin", 32'h1, {31'h0, all_powered_down});
    cmd[4] <= 1'b0;
    wr(8'h02, 8'h07);
    pulse_chk(12, 3, 1);
    wr(8'h02, 8'h03);
    pulse_chk(12, 3, 0);
    wr(8'h02, 8'h02); // software leaves power-down after a wakeup
    $display("test power done");
    wr(8'h80, 8'h02);
    settle();
    chk("clk en ir only", 32'h1, {30'h0, uart_clock_enable, ir_clock_enable});
    wr(8'h80, 8'h01);
    settle();
    chk("clk en uart only", 32'h1, {30'h0, ir_clock_enable, uart_clock_enable});
    wr(8'h80, 8'h03);
    wr(8'h02, 8'h12);
    settle();
    chk("auto save idle", 32'h0, {31'h0, uart_clock_enable});
    cmd[2] <= 1'b1;
    settle();
    chk("auto save access", 32'h1, {31'h0, uart_clock_enable});
    wr(8'h02, 8'h22);
    settle();
    chk("test outputs", 32'h5, {29'h0, general_output});
    wr(8'h02, 8'h02);
    settle();
    chk("normal outputs", 32'h2, {29'h0, general_output});
    wr(8'h70, 8'h0B);
    wr(8'h02, 8'h82);
    settle();
    chk("sw reset", 32'h3, {30'h0, ir_ctrl_reset, subsys_access_block});
    repeat (20) @(posedge clk_sys); // hold time is shortened in this bench
    rdc("cfg kept", 8'h70, 8'h0B);
    wr(8'h02, 8'h02);
    settle();
    chk("sw reset off", 32'h0, {30'h0, ir_ctrl_reset, subsys_access_block});
    wr(8'h02, 8'h42);
    wr(8'h70, 8'h05);
    rdc("locked sel", 8'h70, 8'h0B);
    wr(8'h02, 8'h82);
    rdc("lock kept", 8'h02, 8'h42);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc("lock cleared", 8'h02, 8'h02);
    $display("test lock done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
endmodule : irdcfg_top_tb

`default_nettype wire
